// *** adcddr_capture.sv ***
/*
  Capture logic on the far side of the double data rate link.
  Assumes the strobe edges sit on the word changes, so it samples a quarter period later.
*/
`timescale 1ns/1ns

module adcddr_capture (
  // Forwarded link
  input wire logic i_sample_strobe,
  input wire adcddr_pkg::adcddr_code_t i_result,
  input wire logic i_overrange_flag,
  // Capture status
  output int o_edge_count
);
  logic [12:0] words[$];

  initial o_edge_count = 0;
  // both strobe edges, kept in order
  always @(i_sample_strobe) begin
    #16;
    words.push_back({i_overrange_flag, i_result});
    o_edge_count = o_edge_count + 1;
  end
endmodule

// *** adcddr_cfg.svh ***
/*
  Constants of the converter output block: code widths, coding limits,
  buffer size and the conversion clock figure.
  Assumes it is included by its bare name and holds no logic.
*/
`ifndef ADCDDR_CFG_SVH
`define ADCDDR_CFG_SVH

// Result word and input level widths
`define ADCDDR_CODE_W 12
`define ADCDDR_LEVEL_W 14
`define ADCDDR_SUM_W 15

// Offset binary coding limits
`define ADCDDR_MID_OFFSET 15'sh0800
`define ADCDDR_FULL_SUM 15'sh0FFF
`define ADCDDR_ZERO_SUM 15'sh0000
`define ADCDDR_FULL_CODE 12'hFFF
`define ADCDDR_ZERO_CODE 12'h000

// Sample buffer between system and conversion domains
`define ADCDDR_FIFO_DEPTH 8
`define ADCDDR_FIFO_AW 3

// Conversion clock period used by the bench, in ns
`define ADCDDR_CONV_PERIOD_NS 64

`endif

// *** adcddr_core.sv ***
/*
  Digital side of a 12-bit pipelined sampling converter with a half rate
  double data rate output and a forwarded strobe.
  Assumes the system side feeds signed input levels on i_clk (100 MHz) and
  that the conversion clock is free running with a duty cycle near one half.
*/
`timescale 1ns/1ns
`include "adcddr_cfg.svh"

module adcddr_core (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Input levels from the system side
  input wire logic i_level_valid,
  input wire adcddr_pkg::adcddr_level_t i_level,
  output logic o_level_ready,
  // Run control and status, system side
  input wire logic i_run,
  output logic o_starve,
  // Conversion clock
  input wire logic i_conv_clk,
  // Output link
  output adcddr_pkg::adcddr_code_t o_result,
  output logic o_overrange_flag,
  output logic o_sample_strobe
);
  import adcddr_pkg::*;

  // Conversion domain reset, brought over from the system reset
  logic conv_rst_meta_q;
  logic conv_rst_n_q;
  // Run request, brought over to the conversion domain
  logic run_meta_q;
  logic run_sync_q;
  // Buffer drain side
  logic buf_valid;
  adcddr_level_t buf_level;
  // Pipeline: hN is N half periods after the sampling edge
  adcddr_level_t smp_q;
  adcddr_level_t h1_q;
  adcddr_code_t h2_code_q;
  logic h2_ovr_q;
  adcddr_code_t h3_code_q;
  logic h3_ovr_q;
  adcddr_code_t h4_code_q;
  logic h4_ovr_q;
  adcddr_code_t h5_code_q;
  logic h5_ovr_q;
  adcddr_code_t h6_code_q;
  logic h6_ovr_q;
  // Output link registers
  adcddr_code_t result_q;
  logic ovr_q;
  logic strobe_q;
  // Starvation event, toggled in the conversion domain
  logic starve_tgl_q;
  logic st_meta_q;
  logic st_sync_q;
  logic st_prev_q;
  logic starve_q;

  // Sample buffer; the drain side fills its read register even when stopped, and pulls further words only while running
  adcddr_fifo #(
    .WIDTH(`ADCDDR_LEVEL_W),
    .DEPTH(`ADCDDR_FIFO_DEPTH),
    .AW(`ADCDDR_FIFO_AW)
  ) u_fifo (
    .i_wr_clk(i_clk),
    .i_wr_reset_n(i_reset_n),
    .i_wr_valid(i_level_valid),
    .i_wr_data(i_level),
    .o_wr_ready(o_level_ready),
    .i_rd_clk(i_conv_clk),
    .i_rd_reset_n(conv_rst_n_q),
    .o_rd_valid(buf_valid),
    .o_rd_data(buf_level),
    .i_rd_ready(run_sync_q)
  );

  // Reset release into the conversion domain, two flops
  always_ff @(posedge i_conv_clk) begin
    conv_rst_meta_q <= i_reset_n;
    conv_rst_n_q <= conv_rst_meta_q;
  end

  // Run level into the conversion domain, two flops
  always_ff @(posedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      run_meta_q <= 1'b0;
      run_sync_q <= 1'b0;
    end else begin
      run_meta_q <= i_run;
      run_sync_q <= run_meta_q;
    end
  end

  // Level taken at this edge: a fresh word while running, or the held one when stopped or when the buffer ran dry
  wire take_new = run_sync_q & buf_valid;
  wire adcddr_level_t smp_d = take_new ? buf_level : smp_q;
  wire starve_evt = run_sync_q & ~buf_valid;

  always_ff @(posedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      smp_q <= '0;
    end else begin
      smp_q <= smp_d;
    end
  end

  always_ff @(negedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      h1_q <= '0;
    end else begin
      h1_q <= smp_q;
    end
  end

  // Shift to offset binary: sign extend and add the mid-scale offset
  wire signed [`ADCDDR_SUM_W-1:0] shifted = {h1_q[`ADCDDR_LEVEL_W-1], h1_q} + `ADCDDR_MID_OFFSET;
  wire at_top = (shifted >= `ADCDDR_FULL_SUM);
  wire at_bottom = (shifted <= `ADCDDR_ZERO_SUM);
  wire adcddr_code_t code_d = at_top ? `ADCDDR_FULL_CODE :
                              at_bottom ? `ADCDDR_ZERO_CODE :
                              shifted[`ADCDDR_CODE_W-1:0];
  wire ovr_d = at_top | at_bottom;

  // rising stages at one and two periods
  always_ff @(posedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      h2_code_q <= '0;
      h2_ovr_q <= 1'b0;
      h4_code_q <= '0;
      h4_ovr_q <= 1'b0;
    end else begin
      h2_code_q <= code_d;
      h2_ovr_q <= ovr_d;
      h4_code_q <= h3_code_q;
      h4_ovr_q <= h3_ovr_q;
    end
  end

  // falling stages at one and a half and two and a half periods
  always_ff @(negedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      h3_code_q <= '0;
      h3_ovr_q <= 1'b0;
      h5_code_q <= '0;
      h5_ovr_q <= 1'b0;
    end else begin
      h3_code_q <= h2_code_q;
      h3_ovr_q <= h2_ovr_q;
      h5_code_q <= h4_code_q;
      h5_ovr_q <= h4_ovr_q;
    end
  end

  always_ff @(posedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      h6_code_q <= '0;
      h6_ovr_q <= 1'b0;
    end else begin
      h6_code_q <= h5_code_q;
      h6_ovr_q <= h5_ovr_q;
    end
  end

  // output at three and a half periods
  // strobe toggles with every word
  // The strobe toggling with the data keeps zero skew between them, so the
  // receiver can use both strobe edges; a held strobe would halve its rate.
  always_ff @(negedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      result_q <= '0;
      ovr_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      result_q <= h6_code_q;
      ovr_q <= h6_ovr_q;
      strobe_q <= ~strobe_q;
    end
  end

  // Starvation marks: one toggle per sample taken while running that found no fresh word
  always_ff @(posedge i_conv_clk) begin
    if (!conv_rst_n_q) begin
      starve_tgl_q <= 1'b0;
    end else begin
      starve_tgl_q <= starve_tgl_q ^ starve_evt;
    end
  end

  // Toggle into the system domain; edge taken between second and third flop
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_meta_q <= 1'b0;
      st_sync_q <= 1'b0;
      st_prev_q <= 1'b0;
      starve_q <= 1'b0;
    end else begin
      st_meta_q <= starve_tgl_q;
      st_sync_q <= st_meta_q;
      st_prev_q <= st_sync_q;
      starve_q <= st_sync_q ^ st_prev_q;
    end
  end

  assign o_result = result_q;
  assign o_overrange_flag = ovr_q;
  assign o_sample_strobe = strobe_q;
  assign o_starve = starve_q;
endmodule

// *** adcddr_core_sva.sv ***
/*
  Checker for the converter output block: link timing and status pulses.
  Assumes it is bound to adcddr_core and sees only its ports.
*/
`timescale 1ns/1ns
`include "adcddr_cfg.svh"

module adcddr_core_sva (
  // System side
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic o_level_ready,
  input wire logic i_run,
  input wire logic o_starve,
  // Conversion side
  input wire logic i_conv_clk,
  input wire adcddr_pkg::adcddr_code_t o_result,
  input wire logic o_overrange_flag,
  input wire logic o_sample_strobe
);
  import adcddr_pkg::*;
  logic [3:0] arm_q;
  logic [5:0] idle_q;
  logic [13:0] rise_q;
  wire armed = (arm_q == 4'hF);
  wire at_limit = (o_result == `ADCDDR_FULL_CODE) || (o_result == `ADCDDR_ZERO_CODE);

  // Arm late, so pipeline contents left over from reset are flushed first
  always_ff @(negedge i_conv_clk) begin
    if (!i_reset_n) begin
      arm_q <= 4'h0;
    end else if (!armed) begin
      arm_q <= arm_q + 4'h1;
    end
  end

  // Outputs as they stood at each rising conversion edge
  always_ff @(posedge i_conv_clk) begin
    rise_q <= {o_sample_strobe, o_overrange_flag, o_result};
  end

  // System cycles since run was last high, saturating
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_run) begin
      idle_q <= 6'h00;
    end else if (idle_q != 6'h3F) begin
      idle_q <= idle_q + 6'h01;
    end
  end

  sequence s_quiet5;
    !o_starve [*5];
  endsequence
  sequence s_ready_up;
    !o_level_ready ##1 o_level_ready;
  endsequence

  AST_STROBE_TOGGLE: assert property (@(negedge i_conv_clk) disable iff (!i_reset_n)
    armed |-> o_sample_strobe != $past(o_sample_strobe)) else $error("strobe missed a falling edge");
  AST_HOLD_RISE: assert property (@(negedge i_conv_clk) disable iff (!i_reset_n)
    armed |-> {o_sample_strobe, o_overrange_flag, o_result} == rise_q)
    else $error("link outputs moved on a rising edge");
  AST_OVR_ALIGN: assert property (@(negedge i_conv_clk) disable iff (!i_reset_n)
    armed |-> o_overrange_flag == at_limit) else $error("overrange flag not aligned with limit code");
  AST_WORD_WITH_STROBE: assert property (@(negedge i_conv_clk) disable iff (!i_reset_n)
    armed && o_result != $past(o_result) |-> o_sample_strobe != $past(o_sample_strobe))
    else $error("word changed without a strobe edge");
  AST_STARVE_PULSE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_starve |=> s_quiet5) else $error("starve pulses closer than one conversion");
  AST_STARVE_RUN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_starve |-> idle_q < 6'h28) else $error("starve reported while stopped");
  AST_READY_RELEASE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> s_ready_up) else $error("ready did not rise after reset");
  AST_FULL_HOLDS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    idle_q == 6'h3F && !o_level_ready |=> !o_level_ready) else $error("full buffer freed without draining");
endmodule

// *** adcddr_fifo.sv ***
/*
  Dual clock sample buffer with gray coded pointers and a registered
  read port.
  Assumes each side's reset is synchronous to that side's clock, active low.
*/
`timescale 1ns/1ns

module adcddr_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Fill side
  input wire logic i_wr_clk,
  input wire logic i_wr_reset_n,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  // Drain side
  input wire logic i_rd_clk,
  input wire logic i_rd_reset_n,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_bin_q;
  logic [AW:0] wr_gray_q;
  logic [AW:0] rd_bin_q;
  logic [AW:0] rd_gray_q;
  logic [AW:0] rg_meta_q;
  logic [AW:0] rg_sync_q;
  logic [AW:0] wg_meta_q;
  logic [AW:0] wg_sync_q;
  logic ready_q;
  logic valid_q;
  logic [WIDTH-1:0] data_q;

  // Fill side pointer arithmetic
  wire push = i_wr_valid & ready_q;
  wire [AW:0] wr_bin_d = wr_bin_q + {{AW{1'b0}}, push};
  wire [AW:0] wr_gray_d = wr_bin_d ^ (wr_bin_d >> 1);
  // Full when the next write pointer laps the read pointer once
  wire full_d = (wr_gray_d == {~rg_sync_q[AW:AW-1], rg_sync_q[AW-2:0]});

  // Drain side pointer arithmetic
  wire empty = (rd_gray_q == wg_sync_q);
  wire pop = ~empty & (~valid_q | i_rd_ready);
  wire [AW:0] rd_bin_d = rd_bin_q + {{AW{1'b0}}, pop};
  wire [AW:0] rd_gray_d = rd_bin_d ^ (rd_bin_d >> 1);

  // Storage write
  always_ff @(posedge i_wr_clk) begin
    if (push) begin
      mem_q[wr_bin_q[AW-1:0]] <= i_wr_data;
    end
  end

  // Fill side pointers; ready is registered so the source sees a flop
  always_ff @(posedge i_wr_clk) begin
    if (!i_wr_reset_n) begin
      wr_bin_q <= '0;
      wr_gray_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_bin_q <= wr_bin_d;
      wr_gray_q <= wr_gray_d;
      ready_q <= ~full_d;
    end
  end

  // Read pointer into the fill domain, two flops
  always_ff @(posedge i_wr_clk) begin
    if (!i_wr_reset_n) begin
      rg_meta_q <= '0;
      rg_sync_q <= '0;
    end else begin
      rg_meta_q <= rd_gray_q;
      rg_sync_q <= rg_meta_q;
    end
  end

  // Write pointer into the drain domain, two flops
  always_ff @(posedge i_rd_clk) begin
    if (!i_rd_reset_n) begin
      wg_meta_q <= '0;
      wg_sync_q <= '0;
    end else begin
      wg_meta_q <= wr_gray_q;
      wg_sync_q <= wg_meta_q;
    end
  end

  // Drain side pointers and output register
  always_ff @(posedge i_rd_clk) begin
    if (!i_rd_reset_n) begin
      rd_bin_q <= '0;
      rd_gray_q <= '0;
      valid_q <= 1'b0;
    end else begin
      rd_bin_q <= rd_bin_d;
      rd_gray_q <= rd_gray_d;
      valid_q <= pop | (valid_q & ~i_rd_ready);
    end
  end

  // Read data held until the next pop
  always_ff @(posedge i_rd_clk) begin
    if (pop) begin
      data_q <= mem_q[rd_bin_q[AW-1:0]];
    end
  end

  assign o_wr_ready = ready_q;
  assign o_rd_valid = valid_q;
  assign o_rd_data = data_q;
endmodule

// *** adcddr_pkg.sv ***
/*
  Types shared by the converter output block, its checker, its capture partner and the bench.
  Assumes adcddr_cfg.svh is on the include path.
*/
`include "adcddr_cfg.svh"

package adcddr_pkg;
  // Signed analog level as presented to the track and hold
  typedef logic signed [`ADCDDR_LEVEL_W-1:0] adcddr_level_t;
  // Offset binary result word
  typedef logic [`ADCDDR_CODE_W-1:0] adcddr_code_t;
endpackage

// *** test_adc_pipeline_ddr_output.sv ***
/*
  Self-checking bench for the converter output block with its capture partner.
  Assumes a 100 MHz system clock and a 64 ns conversion clock of unrelated phase.
*/
`timescale 1ns/1ns
`include "adcddr_cfg.svh"

module test_adc_pipeline_ddr_output;
  import adcddr_pkg::*;
  logic i_clk = 1'b0;
  logic i_conv_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_level_valid = 1'b0;
  adcddr_level_t i_level = 14'h0000;
  logic i_run = 1'b0;
  logic o_level_ready, o_starve, o_overrange_flag, o_sample_strobe;
  adcddr_code_t o_result;
  int edges, errors = 0, cmp_count = 0;
  adcddr_level_t lv [16] = '{14'h3FFF, 14'h2000, 14'h3800, 14'h3801, 14'h0000, 14'h0001, 14'h07FE, 14'h07FF,
    14'h0555, 14'h3AAA, 14'h1FFF, 14'h2000, 14'h07FE, 14'h0400, 14'h3C00, 14'h0000};

  // Clocks; conversion clock at even duty
  always #5 i_clk = ~i_clk;
  always #(`ADCDDR_CONV_PERIOD_NS / 2) i_conv_clk = ~i_conv_clk;

  adcddr_core dut (.*);
  adcddr_capture cap (.i_sample_strobe(o_sample_strobe), .i_result(o_result), .i_overrange_flag(o_overrange_flag),
    .o_edge_count(edges));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, want, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // offset binary, clamped and flagged at the limits
  function automatic logic [12:0] expect_of(input adcddr_level_t l);
    int c;
    c = int'(l) + 2048;
    if (c >= 4095) return {1'b1, 12'hFFF};
    if (c <= 0) return {1'b1, 12'h000};
    return {1'b0, c[11:0]};
  endfunction

  task automatic t_reset();
    i_reset_n = 1'b0;
    repeat (30) @(posedge i_clk);
    #1;
    check("ready in reset", o_level_ready, 1'b0);
    check("strobe in reset", o_sample_strobe, 1'b0);
    check("result in reset", o_result, 12'h000);
    i_reset_n = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    check("ready after reset", o_level_ready, 1'b1);
  endtask

  // Fill the buffer while stopped, each level held until taken, then drain and compare
  task automatic t_batch(input int base);
    int k;
    logic [12:0] e;
    k = 0;
    i_level_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      i_level = lv[base + i];
      while (o_level_ready !== 1'b1) begin
        @(posedge i_clk);
        #1;
      end
      @(posedge i_clk);
      #1;
    end
    i_level_valid = 1'b0;
    check("ready when full", o_level_ready, 1'b0);
    cap.words.delete();
    i_run = 1'b1;
    repeat (260) @(posedge i_clk);
    #1;
    i_run = 1'b0;
    e = expect_of(lv[base]);
    while (k < cap.words.size() && cap.words[k] !== e) k++;
    for (int i = 0; i < 9; i++) begin
      e = expect_of(lv[base + (i < 8 ? i : 7)]);
      check("result", cap.words[k + i][11:0], e[11:0]);
      check("overrange", cap.words[k + i][12], e[12]);
    end
    check("ready when drained", o_level_ready, 1'b1);
  endtask

  task automatic t_strobe();
    int c0;
    @(negedge i_conv_clk);
    #40;
    c0 = edges;
    repeat (20) @(negedge i_conv_clk);
    #40;
    check("strobe edges", edges - c0, 20);
  endtask

  // Run with an empty buffer, then stop; an unknown pulse counts as a hit
  task automatic t_starve();
    int hits;
    hits = 0;
    @(posedge i_clk);
    #1;
    i_run = 1'b1;
    repeat (100) begin
      @(posedge i_clk);
      #1;
      hits += (o_starve !== 1'b0);
    end
    i_run = 1'b0;
    check("starve while running", hits != 0, 1'b1);
    repeat (60) @(posedge i_clk);
    hits = 0;
    repeat (100) begin
      @(posedge i_clk);
      #1;
      hits += (o_starve !== 1'b0);
    end
    check("starve while stopped", hits, 0);
  endtask

  initial begin
    @(posedge i_clk);
    #1;
    t_reset();
    t_batch(0);
    t_batch(8);
    t_strobe();
    t_starve();
    t_reset();
    t_batch(0);
    results();
  end

  // Hang guard
  initial begin
    #60000;
    errors++;
    results();
  end
endmodule

bind adcddr_core adcddr_core_sva u_sva (.*);
